// >>> adcc_defs.svh
// register offsets, field positions, reset values and timing counts for the converter control
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

`define ADCC_OFF_CSR      12'h000
`define ADCC_OFF_RES_HIGH 12'h004
`define ADCC_OFF_RES_LOW  12'h008
`define ADCC_OFF_IRQ_STAT 12'h00C
`define ADCC_OFF_IRQ_MASK 12'h010

`define ADCC_CSR_DONE_BIT  7
`define ADCC_CSR_SPEED_BIT 6
`define ADCC_CSR_ON_BIT    5
`define ADCC_CSR_RSVD_BIT  4
`define ADCC_CSR_CH_MSB    3

`define ADCC_CSR_RESET     8'h00
`define ADCC_RES_RESET     10'h000

`define ADCC_DIV_SLOW      3'd4
`define ADCC_DIV_FAST      3'd2
`define ADCC_SAMPLE_TICKS  4'd2

`endif

// >>> adcc_pkg.sv
// types shared by the converter control block
package adcc_pkg;

	// one apb request from the master
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} adcc_apb_req_t;

	// answer back to the master
	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} adcc_apb_rsp_t;

	// converter sequencer states
	typedef enum logic [1:0] {
		ADCC_IDLE,
		ADCC_SAMPLE,
		ADCC_CONVERT
	} adcc_state_t;

endpackage

// >>> adcc_ctrl.sv
// converter control, result registers and successive approximation sequencer behind apb
// Functional notes
// - done flag bit 7 sets at conversion end; cleared by high result read or csr write
// - control/status is read/write except bit 7 which ignores writes
// - converter clock is cpu clock over 4 when speed is 0, over 2 when 1
// - writing on=1 enables and starts conversion; on=0 stops any conversion
// - 4-bit channel select in bits 3:0 picks analog input 0 to 15
// - high result register shows result bits 9:2, read-only
// - low result register shows result bits 1:0, upper bits read zero
// - 10-bit result built by successive approximation with sample and hold
//
// Implementation choices: the APB slave port and the address map.
`include "adcc_defs.svh"

module adcc_ctrl #(
	parameter int RES_W = 10
) (
	// clock and reset
	input  wire logic                   sys_clk_i,
	input  wire logic                   arst_n_i,
	// apb slave
	input  wire adcc_pkg::adcc_apb_req_t apb_req_i,
	output      adcc_pkg::adcc_apb_rsp_t apb_rsp_o,
	// analog front end
	input  wire logic                   cmp_gt_i,
	output      logic [3:0]             mux_sel_o,
	output      logic                   sample_o,
	output      logic [RES_W-1:0]       dac_code_o,
	output      logic                   analog_en_o,
	// interrupt
	output      logic                   irq_o
);
	import adcc_pkg::*;

	logic [7:0]       csr;
	logic [RES_W-1:0] result;
	logic [1:0]       irq_stat;
	logic [1:0]       irq_mask;
	adcc_state_t      state;
	logic [2:0]       div_cnt;
	logic [3:0]       step;
	logic [RES_W-1:0] trial;
	logic [RES_W-1:0] bit_ptr;

	// bus decode
	wire       acc      = apb_req_i.psel & apb_req_i.penable;
	wire       setup    = apb_req_i.psel & ~apb_req_i.penable; // first cycle of a transfer
	wire       wr       = acc & apb_req_i.pwrite;
	wire       rd       = acc & ~apb_req_i.pwrite;
	wire [11:0] a       = apb_req_i.paddr;
	wire       hit_csr  = (a == `ADCC_OFF_CSR);
	wire       hit_hi   = (a == `ADCC_OFF_RES_HIGH);
	wire       hit_lo   = (a == `ADCC_OFF_RES_LOW);
	wire       hit_st   = (a == `ADCC_OFF_IRQ_STAT);
	wire       hit_mk   = (a == `ADCC_OFF_IRQ_MASK);
	wire       mapped   = hit_csr | hit_hi | hit_lo | hit_st | hit_mk;
	wire       csr_wr   = wr & hit_csr;
	wire       hi_rd    = rd & hit_hi;
	wire [7:0] wd       = apb_req_i.pwdata[7:0];

	// converter clock tick: divide by 4 or 2 from the cpu clock
	wire [2:0] div_top  = csr[`ADCC_CSR_SPEED_BIT] ? `ADCC_DIV_FAST : `ADCC_DIV_SLOW;
	wire       tick     = (div_cnt == div_top - 3'd1);
	wire       conv_on  = csr[`ADCC_CSR_ON_BIT];

	// successive approximation: keep the trial bit if input exceeds the dac level
	wire [RES_W-1:0] kept     = cmp_gt_i ? trial : (trial & ~bit_ptr);
	wire             last_bit = bit_ptr[0];
	wire             done_evt = (state == ADCC_CONVERT) & tick & last_bit & conv_on;
	wire             start    = csr_wr & wd[`ADCC_CSR_ON_BIT];

	// read data mux; unused upper bits read zero
	wire [7:0] rd_byte =
		hit_csr ? csr :
		hit_hi  ? result[RES_W-1:RES_W-8] :
		hit_lo  ? {6'b00_0000, result[1:0]} :
		hit_st  ? {6'b00_0000, irq_stat} :
		hit_mk  ? {6'b00_0000, irq_mask} : 8'h00;

	// interrupt events: conversion done and bus error on unmapped address
	wire       err_evt  = acc & ~mapped;
	wire [1:0] evt      = {err_evt, done_evt};
	wire [1:0] st_clr   = (wr & hit_st) ? wd[1:0] : 2'b00;
	wire       irq_any  = |(irq_stat & irq_mask); // level source for the pin

	// next flag value; the hardware set wins over any clear in the same cycle
	wire       done_clr = hi_rd | csr_wr;
	wire       next_done = done_evt | (csr[`ADCC_CSR_DONE_BIT] & ~done_clr);

	// control/status register, bit 7 never taken from the bus
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			csr <= `ADCC_CSR_RESET;
		end else begin
			csr[`ADCC_CSR_DONE_BIT] <= next_done;
			if (csr_wr) begin
				csr[6:0] <= wd[6:0];
			end
		end
	end

	// result loads together with the done flag
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			result <= `ADCC_RES_RESET;
		end else if (done_evt) begin
			result <= kept;
		end
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_stat <= 2'b00;
			irq_mask <= 2'b00;
		end else begin
			irq_stat <= evt | (irq_stat & ~st_clr);
			if (wr & hit_mk) begin
				irq_mask <= wd[1:0];
			end
		end
	end

	// clock divider, restarts on every conversion start so sampling is aligned
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_cnt <= 3'd0;
		end else if (start | tick) begin
			div_cnt <= 3'd0;
		end else begin
			div_cnt <= div_cnt + 3'd1;
		end
	end

	// sequencer: sample for a few converter clocks, then one bit per converter clock
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state   <= ADCC_IDLE;
			step    <= 4'd0;
			trial   <= '0;
			bit_ptr <= '0;
		end else if (start) begin
			state   <= ADCC_SAMPLE;
			step    <= 4'd0;
			trial   <= '0;
			bit_ptr <= '0;
		end else if (!conv_on) begin
			state   <= ADCC_IDLE;
		end else if (tick) begin
			case (state)
				ADCC_SAMPLE: begin
					step <= step + 4'd1;
					if (step == `ADCC_SAMPLE_TICKS - 4'd1) begin
						state   <= ADCC_CONVERT;
						bit_ptr <= {1'b1, {(RES_W-1){1'b0}}};
						trial   <= {1'b1, {(RES_W-1){1'b0}}};
					end
				end
				ADCC_CONVERT: begin
					if (last_bit) begin
						state <= ADCC_IDLE; // single conversion per start
					end else begin
						bit_ptr <= bit_ptr >> 1;
						trial   <= kept | (bit_ptr >> 1);
					end
				end
				default: state <= ADCC_IDLE;
			endcase
		end
	end

	// registered outputs to the bus, analog side and interrupt
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			apb_rsp_o   <= '0;
			mux_sel_o   <= 4'h0;
			sample_o    <= 1'b0;
			dac_code_o  <= '0;
			analog_en_o <= 1'b0;
			irq_o       <= 1'b0;
		end else begin
			apb_rsp_o.pready  <= setup; // zero wait states: every access takes two cycles
			apb_rsp_o.pslverr <= setup & ~mapped;
			apb_rsp_o.prdata  <= {24'h00_0000, rd_byte};
			mux_sel_o   <= csr[`ADCC_CSR_CH_MSB:0];
			sample_o    <= (state == ADCC_SAMPLE);
			dac_code_o  <= trial;
			analog_en_o <= conv_on;
			irq_o       <= irq_any;
		end
	end

	// helper for the checks below: converter ticks since the last start, idle ticks not counted
	logic [4:0] chk_ticks;
	always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			chk_ticks <= 5'h00;
		end else if (start) begin
			chk_ticks <= 5'h00;
		end else if (tick && (state != ADCC_IDLE)) begin
			chk_ticks <= chk_ticks + 5'h01;
		end
	end

	// named steps: flag rise, one divider period per speed, entry into the bit decisions
	sequence s_done_rise;
		!csr[`ADCC_CSR_DONE_BIT] ##1 csr[`ADCC_CSR_DONE_BIT];
	endsequence

	sequence s_slow_gap;
		(tick && !csr[`ADCC_CSR_SPEED_BIT] && !start)
			##1 (!csr[`ADCC_CSR_SPEED_BIT] && !start)[*4];
	endsequence

	sequence s_fast_gap;
		(tick && csr[`ADCC_CSR_SPEED_BIT] && !start)
			##1 (csr[`ADCC_CSR_SPEED_BIT] && !start)[*2];
	endsequence

	sequence s_enter_convert;
		(state == ADCC_SAMPLE) ##1 (state == ADCC_CONVERT);
	endsequence

	// bus side: ready answers the setup cycle, holes give an error, read data for csr and both result registers
	a_ready_pulse: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		apb_rsp_o.pready == $past(setup))
		else $error("ready not one cycle after setup");
	a_err_unmapped: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(setup && !mapped) |=> (apb_rsp_o.pslverr && (apb_rsp_o.prdata == 32'h0000_0000)))
		else $error("unmapped access not refused");
	a_csr_read_data: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(setup && hit_csr) |=> (apb_rsp_o.prdata[7:0] == $past(csr)))
		else $error("control status read wrong");
	a_high_read_data: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(setup && hit_hi) |=> (apb_rsp_o.prdata[7:0] == $past(result[RES_W-1:RES_W-8])))
		else $error("high result read wrong");
	a_low_read_zero: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(setup && hit_lo) |=> (apb_rsp_o.prdata[7:2] == 6'b00_0000))
		else $error("low result upper bits not zero");
	a_low_read_data: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(setup && hit_lo) |=> (apb_rsp_o.prdata[1:0] == $past(result[1:0])))
		else $error("low result bits read wrong");

	// done flag: set by hardware only, cleared by high result read or any csr write
	a_done_from_event: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		s_done_rise |-> $past(done_evt))
		else $error("done flag set without conversion end");
	a_done_sets: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		done_evt |=> csr[`ADCC_CSR_DONE_BIT])
		else $error("done flag missed conversion end");
	a_done_clear_read: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(hi_rd && !done_evt) |=> !csr[`ADCC_CSR_DONE_BIT])
		else $error("done flag survived result read");
	a_done_clear_write: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(csr_wr && !done_evt) |=> !csr[`ADCC_CSR_DONE_BIT])
		else $error("done flag survived csr write");
	a_done_wr_ignore: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(csr_wr && wd[`ADCC_CSR_DONE_BIT] && !done_evt) |=> !csr[`ADCC_CSR_DONE_BIT])
		else $error("bus wrote the done flag");
	a_csr_write_takes: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		csr_wr |=> (csr[6:0] == $past(wd[6:0])))
		else $error("csr write lost");

	// converter clock: four cpu clocks per tick when slow, two when fast
	a_div_slow_period: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		s_slow_gap |-> tick)
		else $error("slow converter clock not divide by four");
	a_div_fast_period: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		s_fast_gap |-> tick)
		else $error("fast converter clock not divide by two");
	a_tick_spacing: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		tick |=> !tick)
		else $error("converter ticks back to back");

	// on/off bit and channel select reach the analog side
	a_off_stops: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(csr_wr && !wd[`ADCC_CSR_ON_BIT]) |=> ##1 (state == ADCC_IDLE))
		else $error("conversion kept running");
	a_start_samples: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		start |=> (state == ADCC_SAMPLE))
		else $error("start did not begin sampling");
	a_analog_follows: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		analog_en_o == $past(csr[`ADCC_CSR_ON_BIT]))
		else $error("analog enable not following on bit");
	a_mux_follows: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		csr_wr |=> ##1 (mux_sel_o == $past(wd[3:0], 2)))
		else $error("channel select not applied");

	// successive approximation: msb first, one bit per tick, result with the flag
	a_convert_msb_first: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		s_enter_convert |-> ((bit_ptr == {1'b1, {(RES_W-1){1'b0}}}) && (trial == bit_ptr)))
		else $error("bit decisions did not start at the msb");
	a_ptr_onehot: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state == ADCC_CONVERT) |-> $onehot(bit_ptr))
		else $error("bit pointer not one hot");
	a_ptr_walks: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(state == ADCC_CONVERT && tick && !last_bit && !start && conv_on)
		|=> (bit_ptr == ($past(bit_ptr) >> 1)))
		else $error("bit pointer skipped a bit");
	a_conv_ticks: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		done_evt |-> (int'(chk_ticks) == int'(`ADCC_SAMPLE_TICKS) + RES_W - 1))
		else $error("conversion length wrong");
	a_result_with_flag: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		$changed(result) |-> csr[`ADCC_CSR_DONE_BIT])
		else $error("result changed apart from done flag");

	// interrupt status clears by writing one, pin follows the unmasked status
	a_stat_clear: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		(wr && hit_st && wd[0] && !done_evt) |=> !irq_stat[0])
		else $error("status bit survived write one");
	a_irq_level: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		irq_o == $past(irq_any))
		else $error("interrupt pin not following status");

endmodule

// >>> adcc_afe_model.sv
// behavioural analog front end: input levels, sample and hold, comparator
module adcc_afe_model (
	// clock
	input  wire logic             sys_clk_i,
	// input levels per channel, in converter codes
	input  wire logic [15:0][9:0] level_i,
	// from the converter control
	input  wire logic [3:0]       mux_sel_i,
	input  wire logic             sample_i,
	input  wire logic [9:0]       dac_code_i,
	input  wire logic             analog_en_i,
	// comparator
	output      logic             cmp_gt_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// held level sits half a step above its code so > and >= give one answer
	logic [10:0] held = '0;

	// track the selected input while sampling, hold it afterwards
	always_ff @(posedge sys_clk_i) begin
		if (sample_i) begin
			held <= {level_i[mux_sel_i], 1'b1};
		end
	end

	// an unpowered comparator gives no decision
	assign cmp_gt_o = analog_en_i & (held > {dac_code_i, 1'b0});
endmodule

// >>> adcc_ctrl_tb.sv
// self-checking bench for the converter control block
`include "adcc_defs.svh"
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
	fail_count++; $display("FAIL %s expected %h seen %h", what, exp, got); end end
module adcc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import adcc_pkg::*;

	logic             sys_clk_i  = 1'b0;
	logic             arst_n_i   = 1'b0;
	adcc_apb_req_t    req        = '0;
	adcc_apb_rsp_t    rsp;
	logic             cmp_gt, sample, analog_en, irq;
	logic [3:0]       mux_sel;
	logic [9:0]       dac_code;
	logic [15:0][9:0] level;
	logic [31:0]      rd;
	logic             err;
	int               fail_count = 0;
	int               n_compared = 0;

	adcc_ctrl dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .apb_req_i(req),
		.apb_rsp_o(rsp), .cmp_gt_i(cmp_gt), .mux_sel_o(mux_sel), .sample_o(sample),
		.dac_code_o(dac_code), .analog_en_o(analog_en), .irq_o(irq));
	adcc_afe_model afe (.sys_clk_i(sys_clk_i), .level_i(level), .mux_sel_i(mux_sel),
		.sample_i(sample), .dac_code_i(dac_code), .analog_en_i(analog_en), .cmp_gt_o(cmp_gt));

	// clock generator
	initial begin
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	// one apb transfer; starts one edge in so a release never meets a new setup
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= wr;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge sys_clk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		if (n >= 50) fail_count++;
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(what, exp, rd)
	endtask

	task automatic t_reset();
		rdchk(`ADCC_OFF_CSR, 32'h0000_0000, "csr reset");
		rdchk(`ADCC_OFF_RES_HIGH, 32'h0000_0000, "high reset");
		rdchk(`ADCC_OFF_RES_LOW, 32'h0000_0000, "low reset");
		apb(1'b1, 12'h014, 32'h0000_00FF);
		`CHK("unmapped err", 1'b1, err)
		rdchk(`ADCC_OFF_IRQ_STAT, 32'h0000_0002, "unmapped status");
		apb(1'b1, `ADCC_OFF_IRQ_STAT, 32'h0000_0002);
	endtask

	// bit 7 written high must not stick; channel reaches the mux
	task automatic t_fields();
		apb(1'b1, `ADCC_OFF_CSR, 32'h0000_00CF);
		rdchk(`ADCC_OFF_CSR, 32'h0000_004F, "csr fields");
		`CHK("mux select", 4'hF, mux_sel)
		apb(1'b1, `ADCC_OFF_CSR, 32'h0000_0000);
	endtask

	// full conversion, timed, then results and flag clearing by high read
	task automatic t_convert(input logic [3:0] ch, input logic spd);
		int cyc;
		int exp;
		logic [9:0] code;
		cyc = 0;
		// two sample ticks and ten bit ticks; irq one cycle after the flag, seen one edge on
		exp = int'(spd ? `ADCC_DIV_FAST : `ADCC_DIV_SLOW) * (int'(`ADCC_SAMPLE_TICKS) + 10) + 2;
		code = level[ch];
		apb(1'b1, `ADCC_OFF_IRQ_MASK, 32'h0000_0001);
		apb(1'b1, `ADCC_OFF_CSR, {24'h0, 1'b0, spd, 2'b10, ch});
		while (irq !== 1'b1 && cyc < 200) begin
			@(posedge sys_clk_i);
			cyc++;
		end
		`CHK("conversion cycles", exp, cyc)
		rdchk(`ADCC_OFF_CSR, {24'h0, 1'b1, spd, 2'b10, ch}, "done set");
		rdchk(`ADCC_OFF_RES_LOW, {30'h0, code[1:0]}, "result low");
		rdchk(`ADCC_OFF_RES_HIGH, {24'h0, code[9:2]}, "result high");
		rdchk(`ADCC_OFF_CSR, {24'h0, 1'b0, spd, 2'b10, ch}, "done cleared");
		apb(1'b1, `ADCC_OFF_IRQ_STAT, 32'h0000_0001);
		repeat (3) @(posedge sys_clk_i);
		`CHK("irq cleared", 1'b0, irq)
	endtask

	// converter off in mid conversion: nothing completes
	task automatic t_stop();
		apb(1'b1, `ADCC_OFF_CSR, 32'h0000_0025);
		repeat (10) @(posedge sys_clk_i);
		apb(1'b1, `ADCC_OFF_CSR, 32'h0000_0000);
		repeat (80) @(posedge sys_clk_i);
		`CHK("stopped irq", 1'b0, irq)
		`CHK("analog off", 1'b0, analog_en)
		rdchk(`ADCC_OFF_IRQ_STAT, 32'h0000_0000, "no done after stop");
	endtask

	// masked completion, then flag cleared by a csr write
	task automatic t_wclear();
		apb(1'b1, `ADCC_OFF_IRQ_MASK, 32'h0000_0000);
		apb(1'b1, `ADCC_OFF_CSR, 32'h0000_0023);
		repeat (70) @(posedge sys_clk_i);
		`CHK("masked irq", 1'b0, irq)
		rdchk(`ADCC_OFF_IRQ_STAT, 32'h0000_0001, "status done");
		rdchk(`ADCC_OFF_CSR, 32'h0000_00A3, "done masked");
		apb(1'b1, `ADCC_OFF_CSR, 32'h0000_0083);
		rdchk(`ADCC_OFF_CSR, 32'h0000_0003, "done write clear");
	endtask

	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// watchdog, far beyond the hundred or so cycles each scenario needs
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fail_count++;
		complete_run();
	end

	// main sequence
	initial begin
		for (int c = 0; c < 16; c++) level[c] = 10'(c * 61 + 7);
		repeat (4) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_fields();
		t_convert(4'h0, 1'b0);
		t_convert(4'h5, 1'b1);
		t_convert(4'hF, 1'b0);
		t_stop();
		t_wclear();
		complete_run();
	end
endmodule
